// file: hdl/adc_top.v
// adc_top.v: command decode, status views, device control, drive state input
// assumes: host port strobes and address come from synchronous host-side logic;
// write gate, head and drive select levels are asynchronous pins
`include "adc_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module adc_top (
    // clock and reset
    input wire clock_in,
    input wire software_reset_hold_in,
    // host port
    input wire [9:0] port_addr_in,
    input wire port_wr_in,
    input wire port_rd_in,
    input wire [7:0] port_wdata_in,
    output reg [7:0] port_rdata_out,
    output wire port_rdata_b7_oe_out,
    // drive side status from execution engine
    input wire cmd_done_in,
    input wire irq_event_in,
    input wire [6:0] status_low_in,
    // drive pins
    input wire write_gate_sense_n_in,
    input wire [3:0] head_select_in,
    input wire drive_sel_in,
    // host interrupt line, open drive
    output wire host_irq_out,
    output wire host_irq_oe_out,
    // decoded command
    output reg cmd_start_out,
    output reg cmd_abort_out,
    output reg [4:0] cmd_op_out,
    output reg cmd_noretry_out,
    output reg cmd_long_out,
    output reg cmd_timeout_load_out,
    output reg [5:0] cmd_params_out,
    // control
    output wire software_reset_hold_out,
    output wire host_irq_disable_out
);

// ==========================================
// decode functions
function [4:0] op_of;
    input [7:0] code;
    begin
        op_of = `ADC_OP_INVALID;
        if (code[7:4] == 4'h7) begin
            op_of = `ADC_OP_SEEK;
        end else if (code[7:4] == 4'h1) begin
            op_of = `ADC_OP_RECAL;
        end else begin
            case (code)
                8'h20, 8'h21, 8'h22, 8'h23: op_of = `ADC_OP_READ;
                8'h30, 8'h31, 8'h32, 8'h33: op_of = `ADC_OP_WRITE;
                8'h40, 8'h41: op_of = `ADC_OP_VERIFY;
                8'h3c: op_of = `ADC_OP_WR_VERIFY;
                8'hc8, 8'hc9: op_of = `ADC_OP_DMA_READ;
                8'hca, 8'hcb: op_of = `ADC_OP_DMA_WRITE;
                8'hc4: op_of = `ADC_OP_MULT_READ;
                8'hc5: op_of = `ADC_OP_MULT_WRITE;
                8'hc6: op_of = `ADC_OP_SET_MULT;
                8'he4: op_of = `ADC_OP_BUF_READ;
                8'he8: op_of = `ADC_OP_BUF_WRITE;
                8'hef: op_of = `ADC_OP_FEATURES;
                8'h50: op_of = `ADC_OP_FORMAT;
                8'h90: op_of = `ADC_OP_DIAG;
                8'h94, 8'he0: op_of = `ADC_OP_STANDBY_NOW;
                8'h95, 8'he1: op_of = `ADC_OP_IDLE_NOW;
                8'h96, 8'he2: op_of = `ADC_OP_STANDBY;
                8'h97, 8'he3: op_of = `ADC_OP_IDLE;
                8'h98, 8'he5: op_of = `ADC_OP_POWER_QUERY;
                8'h99, 8'he6: op_of = `ADC_OP_SLEEP;
                8'hf8: op_of = `ADC_OP_NATIVE_MAX;
                8'hf9: op_of = `ADC_OP_SET_MAX;
                8'hec: op_of = `ADC_OP_IDENTIFY;
                8'h91: op_of = `ADC_OP_INIT_GEOM;
                default: op_of = `ADC_OP_INVALID;
            endcase
        end
    end
endfunction

function [5:0] params_of;
    input [4:0] op;
    begin
        case (op)
            `ADC_OP_READ, `ADC_OP_WRITE, `ADC_OP_VERIFY, `ADC_OP_WR_VERIFY,
            `ADC_OP_DMA_READ, `ADC_OP_DMA_WRITE, `ADC_OP_MULT_READ,
            `ADC_OP_MULT_WRITE, `ADC_OP_SET_MAX:
                params_of = `ADC_PU_SC | `ADC_PU_SN | `ADC_PU_CYL | `ADC_PU_SDH;
            `ADC_OP_SEEK: params_of = `ADC_PU_SN | `ADC_PU_CYL | `ADC_PU_SDH;
            `ADC_OP_FORMAT: params_of = `ADC_PU_CYL | `ADC_PU_SDH;
            `ADC_OP_FEATURES: params_of = `ADC_PU_F | `ADC_PU_DRV;
            `ADC_OP_INIT_GEOM: params_of = `ADC_PU_SC | `ADC_PU_SDH;
            `ADC_OP_SET_MULT: params_of = `ADC_PU_SC | `ADC_PU_DRV;
            `ADC_OP_NATIVE_MAX: params_of = `ADC_PU_SDH;
            `ADC_OP_DIAG, `ADC_OP_IDENTIFY, `ADC_OP_BUF_READ, `ADC_OP_BUF_WRITE,
            `ADC_OP_RECAL:
                params_of = `ADC_PU_DRV;
            default: params_of = 6'h00;
        endcase
    end
endfunction

// variant bits only mean something for the read, write, verify and dma read/write classes
function has_retry_bit;
    input [4:0] op;
    begin
        has_retry_bit = (op == `ADC_OP_READ) || (op == `ADC_OP_WRITE) ||
            (op == `ADC_OP_VERIFY) || (op == `ADC_OP_DMA_READ) ||
            (op == `ADC_OP_DMA_WRITE);
    end
endfunction

// ==========================================
// pin synchronisers
reg [5:0] pin_meta_reg;
reg [5:0] pin_sync_reg;

always @(posedge clock_in) begin
    pin_meta_reg <= {write_gate_sense_n_in, head_select_in, drive_sel_in};
    pin_sync_reg <= pin_meta_reg;
end

// ==========================================
// state
reg busy_reg;
reg irq_pend_reg;
reg software_reset_hold_hold_reg;
reg irq_dis_reg;
reg [7:0] digin_reg;

wire cmd_wr = port_wr_in && (port_addr_in == `ADC_PORT_STATUS) && !software_reset_hold_hold_reg;
wire ctl_wr = port_wr_in && (port_addr_in == `ADC_PORT_ALTCTL);
wire sts_rd = port_rd_in && (port_addr_in == `ADC_PORT_STATUS);
wire [4:0] op_now = op_of(port_wdata_in);
wire [7:0] status_byte = {busy_reg, status_low_in};

assign software_reset_hold_out = software_reset_hold_hold_reg;
assign host_irq_disable_out = irq_dis_reg;
assign host_irq_out = irq_pend_reg;
assign host_irq_oe_out = !irq_dis_reg;
assign port_rdata_b7_oe_out = !(port_addr_in == `ADC_PORT_DIGIN);

// ==========================================
// device control register
always @(posedge clock_in) begin
    if (software_reset_hold_in) begin
        software_reset_hold_hold_reg <= 1'b0;
        irq_dis_reg <= 1'b0;
    end else if (ctl_wr) begin
        software_reset_hold_hold_reg <= port_wdata_in[`ADC_CTL_SOFTWARE_RESET_HOLD_BIT];
        irq_dis_reg <= port_wdata_in[`ADC_CTL_IRQDIS_BIT];
    end
end

// ==========================================
// busy, interrupt and command launch
always @(posedge clock_in) begin
    if (software_reset_hold_in || software_reset_hold_hold_reg) begin
        // held in reset while the software reset bit is set
        busy_reg <= 1'b1;
        irq_pend_reg <= 1'b0;
        cmd_start_out <= 1'b0;
        cmd_abort_out <= 1'b0;
        cmd_op_out <= `ADC_OP_INVALID;
        cmd_noretry_out <= 1'b0;
        cmd_long_out <= 1'b0;
        cmd_timeout_load_out <= 1'b0;
        cmd_params_out <= 6'h00;
    end else begin
        cmd_start_out <= 1'b0;
        cmd_abort_out <= 1'b0;
        if (cmd_wr) begin
            busy_reg <= 1'b1;
            cmd_op_out <= op_now;
            cmd_params_out <= params_of(op_now);
            cmd_noretry_out <= has_retry_bit(op_now) &&
                port_wdata_in[`ADC_CODE_NORETRY_BIT];
            cmd_long_out <= ((op_now == `ADC_OP_READ) || (op_now == `ADC_OP_WRITE)) &&
                port_wdata_in[`ADC_CODE_LONG_BIT];
            cmd_timeout_load_out <= (op_now == `ADC_OP_STANDBY) ||
                (op_now == `ADC_OP_IDLE);
            if (op_now == `ADC_OP_INVALID) begin
                cmd_abort_out <= 1'b1;
            end else begin
                cmd_start_out <= 1'b1;
            end
        end else if (cmd_done_in) begin
            busy_reg <= 1'b0;
        end
        // a new event wins over a clearing read or command write
        if (irq_event_in) begin
            irq_pend_reg <= 1'b1;
        end else if (cmd_wr || sts_rd) begin
            irq_pend_reg <= 1'b0;
        end
    end
end

// ==========================================
// digital input register
always @(posedge clock_in) begin
    if (software_reset_hold_in) begin
        digin_reg <= 8'h00;
    end else begin
        digin_reg[7] <= 1'b0;
        digin_reg[6] <= pin_sync_reg[5];
        digin_reg[5:2] <= ~pin_sync_reg[4:1];
        digin_reg[1] <= !pin_sync_reg[0];
        digin_reg[0] <= pin_sync_reg[0];
    end
end

// ==========================================
// read data
always @(posedge clock_in) begin
    if (software_reset_hold_in) begin
        port_rdata_out <= 8'h00;
    end else if (port_addr_in == `ADC_PORT_STATUS ||
                 port_addr_in == `ADC_PORT_ALTCTL) begin
        port_rdata_out <= status_byte;
    end else if (port_addr_in == `ADC_PORT_DIGIN) begin
        port_rdata_out <= digin_reg;
    end else begin
        port_rdata_out <= 8'h00;
    end
end

endmodule

`default_nettype wire

// file: pkg/adc_defs.vh
// adc_defs.vh: constants for the drive command decode and control block
// assumes: included by hdl/adc_top.v; byte-wide host port, 125 MHz clock
// Functional notes
// - command write sets busy, drops pending irq, aborts unknown codes
// - 20h normal read with retries, 21h without; bit 0 kills retries
// - 22h long read with retries, 23h long read without; bit 1 long
// - 30h normal write with retries, 31h without retries
// - 32h long write with retries, 33h long write without retries
// - 40h verify with retries, 41h without, 3ch write then verify
// - c8/c9 dma read, ca/cb dma write, c4/c5 multiple, c6, e4, e8, ef
// - 7xh seek, 1xh recalibrate, 50h format, 90h diagnostic
// - 94h/e0h standby now, 95h/e1h idle now, timeout kept
// - 96h/e2h standby, 97h/e3h idle load timeout; 98h/e5h query, 99h/e6h sleep
// - f8h native max, f9h set max, ech identify, 91h init geometry
// - each command flags which parameter registers it uses
// - alternate status read equals status, leaves irq pending
// - control write: bit 2 software reset, bit 1 irq disable
// - device stays in reset while software reset bit is set
// - irq line driven when disable is 0, released when 1
// - pending irq appears when disable clears; disable resets to 0
// - digital input read leaves data bit 7 undriven; writes ignored
// - bit 6 write gate, bits 5..2 inverted head number
// - bit 1 low if drive 1 selected, bit 0 low if drive 0
// - main status read clears pending irq
// - busy is bit 7 of both status views
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// ==========================================
// port addresses
`define ADC_PORT_STATUS 10'h1f7
`define ADC_PORT_ALTCTL 10'h3f6
`define ADC_PORT_DIGIN 10'h3f7

// ==========================================
// field positions
`define ADC_CTL_SOFTWARE_RESET_HOLD_BIT 2
`define ADC_CTL_IRQDIS_BIT 1
`define ADC_STS_BUSY_BIT 7
`define ADC_CODE_NORETRY_BIT 0
`define ADC_CODE_LONG_BIT 1

// ==========================================
// operation classes
`define ADC_OP_INVALID 5'h00
`define ADC_OP_READ 5'h01
`define ADC_OP_WRITE 5'h02
`define ADC_OP_VERIFY 5'h03
`define ADC_OP_WR_VERIFY 5'h04
`define ADC_OP_DMA_READ 5'h05
`define ADC_OP_DMA_WRITE 5'h06
`define ADC_OP_MULT_READ 5'h07
`define ADC_OP_MULT_WRITE 5'h08
`define ADC_OP_SET_MULT 5'h09
`define ADC_OP_BUF_READ 5'h0a
`define ADC_OP_BUF_WRITE 5'h0b
`define ADC_OP_FEATURES 5'h0c
`define ADC_OP_SEEK 5'h0d
`define ADC_OP_RECAL 5'h0e
`define ADC_OP_FORMAT 5'h0f
`define ADC_OP_DIAG 5'h10
`define ADC_OP_STANDBY_NOW 5'h11
`define ADC_OP_IDLE_NOW 5'h12
`define ADC_OP_STANDBY 5'h13
`define ADC_OP_IDLE 5'h14
`define ADC_OP_POWER_QUERY 5'h15
`define ADC_OP_SLEEP 5'h16
`define ADC_OP_NATIVE_MAX 5'h17
`define ADC_OP_SET_MAX 5'h18
`define ADC_OP_IDENTIFY 5'h19
`define ADC_OP_INIT_GEOM 5'h1a

// ==========================================
// parameter use mask: features, count, start, cylinder, drive/head, drive only
`define ADC_PU_F 6'h20
`define ADC_PU_SC 6'h10
`define ADC_PU_SN 6'h08
`define ADC_PU_CYL 6'h04
`define ADC_PU_SDH 6'h02
`define ADC_PU_DRV 6'h01

// ==========================================
// timing
`define ADC_CLK_NS 8
`define ADC_SOFTWARE_RESET_HOLD_MIN_NS 5000
`define ADC_SOFTWARE_RESET_HOLD_MIN_CYC ((`ADC_SOFTWARE_RESET_HOLD_MIN_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

// file: verif/adc_top_checker.sv
// adc_top_checker.sv: assertions on the adc_top ports
// assumes: bound to adc_top, one clock, synchronous high reset
`timescale 1ns/10ps
`default_nettype none
`include "adc_defs.vh"
module adc_top_checker (
    // clock, reset, inputs
    input wire logic clock_in,
    input wire logic software_reset_hold_in,
    input wire logic [9:0] port_addr_in,
    input wire logic port_wr_in,
    input wire logic port_rd_in,
    input wire logic [7:0] port_wdata_in,
    input wire logic irq_event_in,
    // outputs watched
    input wire logic port_rdata_b7_oe_out,
    input wire logic host_irq_out,
    input wire logic host_irq_oe_out,
    input wire logic cmd_start_out,
    input wire logic cmd_abort_out,
    input wire logic [4:0] cmd_op_out,
    input wire logic cmd_noretry_out,
    input wire logic software_reset_hold_out,
    input wire logic host_irq_disable_out
);
    // ==========================================
    // helpers
    default clocking @(posedge clock_in); endclocking
    default disable iff (software_reset_hold_in);
    wire logic cmd_wr = port_wr_in && port_addr_in == `ADC_PORT_STATUS;
    wire logic alt_acc = port_addr_in == `ADC_PORT_ALTCTL;
    // ==========================================
    // assertions
    cmd_launch_a: assert property (cmd_wr && !software_reset_hold_out |=>
        cmd_start_out != cmd_abort_out) else $error("command gave no single start or abort");
    cmd_irq_clear_a: assert property (cmd_wr && !software_reset_hold_out && !irq_event_in
        |=> !host_irq_out) else $error("command write left irq pending");
    read_noretry_a: assert property (cmd_wr && !software_reset_hold_out && port_wdata_in == 8'h21
        |=> cmd_start_out && cmd_noretry_out && cmd_op_out == `ADC_OP_READ) else $error("21h decode");
    alt_keeps_irq_a: assert property (port_rd_in && alt_acc && host_irq_out |=> host_irq_out)
        else $error("alternate status read cleared irq");
    status_clears_a: assert property (port_rd_in && port_addr_in == `ADC_PORT_STATUS
        && !irq_event_in |=> !host_irq_out) else $error("status read left irq pending");
    ctl_load_a: assert property (port_wr_in && alt_acc |=>
        {software_reset_hold_out, host_irq_disable_out} == $past(port_wdata_in[2:1]))
        else $error("control write not loaded");
    irq_tristate_a: assert property (host_irq_oe_out == !host_irq_disable_out)
        else $error("irq enable does not follow disable bit");
    digin_b7_float_a: assert property (port_addr_in == `ADC_PORT_DIGIN |-> !port_rdata_b7_oe_out)
        else $error("data bit 7 driven on digital input read");
    software_reset_hold_blocks_a: assert property (cmd_wr && software_reset_hold_out |=>
        !cmd_start_out && !cmd_abort_out) else $error("command taken during software reset");
endmodule
bind adc_top adc_top_checker u_chk (.clock_in, .software_reset_hold_in, .port_addr_in, .port_wr_in,
    .port_rd_in, .port_wdata_in, .irq_event_in, .port_rdata_b7_oe_out, .host_irq_out,
    .host_irq_oe_out, .cmd_start_out, .cmd_abort_out, .cmd_op_out, .cmd_noretry_out,
    .software_reset_hold_out, .host_irq_disable_out);
`default_nettype wire

// file: verif/adc_host_model.sv
// adc_host_model.sv: host side of the i/o port, byte reads and writes
// assumes: inputs to adc_top change on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    // clock
    input wire logic clock_in,
    // host port
    output logic [9:0] port_addr_out,
    output logic port_wr_out,
    output logic port_rd_out,
    output logic [7:0] port_wdata_out,
    input wire logic [7:0] port_rdata_in
);
    initial begin
        port_addr_out = 10'h000;
        port_wr_out = 1'b0;
        port_rd_out = 1'b0;
        port_wdata_out = 8'h00;
    end
    // ==========================================
    // one strobed write, released afterwards
    task automatic wr_port(input logic [9:0] a, input logic [7:0] d);
        @(negedge clock_in);
        port_addr_out = a;
        port_wdata_out = d;
        port_wr_out = 1'b1;
        @(negedge clock_in);
        port_wr_out = 1'b0;
        port_addr_out = 10'h000;
        port_wdata_out = ~d;
    endtask
    // ==========================================
    // one strobed read, data taken a cycle later
    task automatic rd_port(input logic [9:0] a, output logic [7:0] d);
        @(negedge clock_in);
        port_addr_out = a;
        port_rd_out = 1'b1;
        @(negedge clock_in);
        d = port_rdata_in;
        port_rd_out = 1'b0;
        port_addr_out = 10'h000;
    endtask
endmodule
`default_nettype wire

// file: verif/test_adc_top.sv
// test_adc_top.sv: self-checking bench for adc_top
// assumes: adc_host_model drives the port, bench drives engine and drive pins
`timescale 1ns/10ps
`default_nettype none
`include "adc_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_adc_top;
    logic clock_in = 1'b0, software_reset_hold_in = 1'b1, port_wr_in, port_rd_in;
    logic cmd_done_in = 1'b0, irq_event_in = 1'b0, write_gate_sense_n_in = 1'b1;
    logic drive_sel_in = 1'b0, port_rdata_b7_oe_out, host_irq_out, host_irq_oe_out;
    logic cmd_start_out, cmd_abort_out, cmd_noretry_out, cmd_long_out, cmd_timeout_load_out;
    logic software_reset_hold_out, host_irq_disable_out;
    logic [9:0] port_addr_in;
    logic [7:0] port_wdata_in, port_rdata_out, d;
    logic [4:0] cmd_op_out;
    logic [5:0] cmd_params_out;
    logic [3:0] head_select_in = 4'h0;
    logic [6:0] status_low_in = 7'h55;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    // code, op, {skip variants, noretry, long, timeout load}, params or ff
    logic [27:0] tbl [45] = '{28'h200101e, 28'h210141e, 28'h220121e, 28'h230161e, 28'h300201e,
        28'h310241e, 28'h320221e, 28'h330261e, 28'h400301e, 28'h410341e, 28'h3c0481e,
        28'hc80501e, 28'hc90541e, 28'hca0601e, 28'hcb0641e, 28'hc40781e, 28'h00008ff,
        28'hc50881e, 28'hc609811, 28'he40a801, 28'he80b801, 28'hef0c821, 28'h750d80e,
        28'h700d80e, 28'h1a0e801, 28'h1f0e801, 28'h500f806, 28'h9010801, 28'h94118ff,
        28'he0118ff, 28'h95128ff, 28'he1128ff, 28'h96139ff, 28'he2139ff, 28'h97149ff,
        28'he3149ff, 28'h98158ff, 28'he5158ff, 28'h99168ff, 28'he6168ff, 28'hf817802,
        28'hf91881e, 28'hec19801, 28'h911a812, 28'hff008ff};
    adc_host_model host (.clock_in, .port_addr_out(port_addr_in), .port_wr_out(port_wr_in),
        .port_rd_out(port_rd_in), .port_wdata_out(port_wdata_in), .port_rdata_in(port_rdata_out));
    adc_top DUT (.clock_in, .software_reset_hold_in, .port_addr_in, .port_wr_in, .port_rd_in, .port_wdata_in,
        .port_rdata_out, .port_rdata_b7_oe_out, .cmd_done_in, .irq_event_in, .status_low_in,
        .write_gate_sense_n_in, .head_select_in, .drive_sel_in, .host_irq_out, .host_irq_oe_out,
        .cmd_start_out, .cmd_abort_out, .cmd_op_out, .cmd_noretry_out, .cmd_long_out,
        .cmd_timeout_load_out, .cmd_params_out, .software_reset_hold_out, .host_irq_disable_out);
    // ==========================================
    // clock, timeout, closing report
    initial forever #4 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task irq_pulse;
        @(negedge clock_in) irq_event_in = 1'b1;
        @(negedge clock_in) irq_event_in = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask
    // ==========================================
    // scenarios
    initial begin
        repeat (6) @(negedge clock_in);
        software_reset_hold_in = 1'b0;
        `CHK({host_irq_oe_out, host_irq_disable_out}, 2'b10)
        @(negedge clock_in) cmd_done_in = 1'b1;
        @(negedge clock_in) cmd_done_in = 1'b0;
        host.rd_port(`ADC_PORT_STATUS, d);
        `CHK(d, 8'h55)
        foreach (tbl[i]) begin
            host.wr_port(`ADC_PORT_STATUS, tbl[i][27:20]);
            `CHK({cmd_start_out, cmd_abort_out}, (tbl[i][19:12] == 8'h00) ? 2'b01 : 2'b10)
            if (tbl[i][19:12] != 8'h00) `CHK(cmd_op_out, tbl[i][16:12])
            `CHK(cmd_timeout_load_out, tbl[i][8])
            if (!tbl[i][11]) `CHK({cmd_noretry_out, cmd_long_out}, tbl[i][10:9])
            if (tbl[i][7:0] != 8'hff) `CHK(cmd_params_out, tbl[i][5:0])
        end
        host.rd_port(`ADC_PORT_ALTCTL, d);
        `CHK(d, 8'hd5)
        irq_pulse();
        host.rd_port(`ADC_PORT_ALTCTL, d);
        `CHK(host_irq_out, 1'b1)
        host.rd_port(`ADC_PORT_STATUS, d);
        `CHK(host_irq_out, 1'b0)
        irq_pulse();
        host.wr_port(`ADC_PORT_STATUS, 8'h20);
        `CHK(host_irq_out, 1'b0)
        host.wr_port(`ADC_PORT_ALTCTL, 8'h02);
        `CHK({host_irq_oe_out, host_irq_disable_out}, 2'b01)
        irq_pulse();
        host.wr_port(`ADC_PORT_ALTCTL, 8'h00);
        `CHK({host_irq_oe_out, host_irq_out}, 2'b11)
        host.wr_port(`ADC_PORT_ALTCTL, 8'h04);
        `CHK(software_reset_hold_out, 1'b1)
        host.wr_port(`ADC_PORT_STATUS, 8'h20);
        `CHK({cmd_start_out, cmd_abort_out}, 2'b00)
        @(negedge clock_in) cmd_done_in = 1'b1;
        @(negedge clock_in) cmd_done_in = 1'b0;
        host.rd_port(`ADC_PORT_STATUS, d);
        `CHK(d[7], 1'b1)
        repeat (`ADC_SOFTWARE_RESET_HOLD_MIN_CYC) @(negedge clock_in);
        host.wr_port(`ADC_PORT_ALTCTL, 8'h00);
        host.wr_port(`ADC_PORT_STATUS, 8'h21);
        `CHK({software_reset_hold_out, cmd_start_out}, 2'b01)
        write_gate_sense_n_in = 1'b0;
        head_select_in = 4'h5;
        drive_sel_in = 1'b1;
        repeat (5) @(negedge clock_in);
        fork
            host.rd_port(`ADC_PORT_DIGIN, d);
            begin
                repeat (2) @(posedge clock_in);
                `CHK(port_rdata_b7_oe_out, 1'b0)
            end
        join
        `CHK(port_rdata_b7_oe_out, 1'b1)
        `CHK(d[6:0], 7'h29)
        `CHK(d[7], 1'b0)
        write_gate_sense_n_in = 1'b1;
        head_select_in = 4'hf;
        drive_sel_in = 1'b0;
        host.wr_port(`ADC_PORT_DIGIN, 8'hff);
        repeat (5) @(negedge clock_in);
        host.rd_port(`ADC_PORT_DIGIN, d);
        `CHK(d[6:0], 7'h42)
        host.rd_port(10'h100, d);
        `CHK(d, 8'h00)
        end_of_test();
    end
endmodule
`default_nettype wire
